/* test/mfic_core_model.sv */
// Core model: program counter and return stack beside the controller
`timescale 1ns/1ps
module mfic_core_model
  import mfic_pkg::*;
#(
  parameter int DEPTH = 2,
  parameter logic [PC_W-1:0] START_PC = 12'h100
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic doRet,
  input wire logic stackPush,
  input wire logic [PC_W-1:0] stackPushAddr,
  input wire logic pcLoad,
  input wire logic [PC_W-1:0] pcLoadAddr,
  output logic [PC_W-1:0] nextPc,
  output logic stackFull,
  output logic retInstr,
  output logic [PC_W-1:0] popAddr
);
  logic [PC_W-1:0] stack [DEPTH];
  int depth;
  assign stackFull = (depth == DEPTH);
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      nextPc <= START_PC;
      depth <= 0;
      retInstr <= 1'b0;
      popAddr <= '0;
    end
    else
    begin
      retInstr <= 1'b0;
      // Pop address is inverted every cycle without a pop, so a stale address returns every second cycle
      popAddr <= ~popAddr;
      if (pcLoad)
        nextPc <= pcLoadAddr;
      if (stackPush && depth < DEPTH)
      begin
        stack[depth] <= stackPushAddr;
        depth <= depth + 1;
      end
      else if (doRet && depth > 0)
      begin
        retInstr <= 1'b1;
        popAddr <= stack[depth-1];
        depth <= depth - 1;
      end
    end
  end
endmodule : mfic_core_model

/* test/tb_top.sv */
// Testbench of the multi-function interrupt controller
`timescale 1ns/1ps
module tb_top
  import mfic_pkg::*;
;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, extPin2 = 0, extPin3 = 0, doRet = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [16:0] evt = 17'h0;
  logic pready, pslverr, stackPush, pcLoad, wake, stackFull, retInstr, errv;
  logic [PC_W-1:0] stackPushAddr, pcLoadAddr, nextPc, popAddr;
  logic [3:0] groupSet, grpSeen = 4'h0;
  logic [PC_W-1:0] loadLog [32], pushLog [32];
  int fail_count = 0, tests_run = 0, loadCnt = 0, pushCnt = 0, wakeCnt = 0, w0;
  logic [7:0] wpat [7] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hbb, 8'h33, 8'hff};
  logic [7:0] rexp [7] = '{8'hff, 8'hff, 8'hff, 8'h33, 8'hbb, 8'h33, 8'h33};
  logic [7:0] eexp [7] = '{8'h00, 8'hf0, 8'hf0, 8'h30, 8'hb0, 8'h30, 8'h30};

  always #20 clock = ~clock;

  mfic_ctrl dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extPin2(extPin2), .extPin3(extPin3), .tmr0Event(evt[16:13]), .tmr1Event(evt[12:9]),
    .tmr2Event(evt[8:7]), .serialEvent(evt[6]), .eepromEvent(evt[5]), .lowVoltEvent(evt[4]),
    .tmr3Event(evt[3:2]), .uartEvent(evt[1:0]), .nextPc(nextPc), .stackFull(stackFull),
    .retInstr(retInstr), .popAddr(popAddr), .stackPush(stackPush), .stackPushAddr(stackPushAddr),
    .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr), .groupSet(groupSet), .wake(wake));

  mfic_core_model #(.DEPTH(2), .START_PC(12'h100)) core_u (.clock(clock), .rst(rst), .doRet(doRet),
    .stackPush(stackPush), .stackPushAddr(stackPushAddr), .pcLoad(pcLoad), .pcLoadAddr(pcLoadAddr),
    .nextPc(nextPc), .stackFull(stackFull), .retInstr(retInstr), .popAddr(popAddr));

  // ==========================================================
  // Monitor of core-side pulses
  // ==========================================================
  // Sampled mid-cycle, away from the edge that launches the pulses
  always @(negedge clock)
  begin
    if (pcLoad === 1'b1)
      loadLog[loadCnt++] = pcLoadAddr;
    if (stackPush === 1'b1)
      pushLog[pushCnt++] = stackPushAddr;
    if (wake === 1'b1)
      wakeCnt++;
    grpSeen = grpSeen | groupSet;
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    // Answer looked at mid-cycle; it stands through the completing edge
    @(negedge clock);
    while (pready !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    if (pready !== 1'b1)
      fail_count++;
    rdv = prdata;
    errv = pslverr;
    // Release only after the completing edge
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rdchk(input logic [7:0] addr, input logic [7:0] exp);
    apb(1'b0, addr, 8'h00);
    chk("register", rdv, {24'h0, exp});
  endtask : rdchk

  task pulse(input logic [16:0] v);
    @(posedge clock);
    evt <= v;
    @(posedge clock);
    evt <= 17'h0;
  endtask : pulse

  task wait_load(input int target);
    int n;
    n = 0;
    while (loadCnt < target && n < 30)
    begin
      @(negedge clock);
      n++;
    end
    chk("load count", loadCnt, target);
  endtask : wait_load

  task ret;
    @(posedge clock);
    doRet <= 1'b1;
    @(posedge clock);
    doRet <= 1'b0;
  endtask : ret

  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial
  begin
    #100000;
    fail_count++;
    end_of_test();
  end

  // ==========================================================
  // Tests
  // ==========================================================
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < NUM_REG; i++) rdchk(REG_OFF[i], 8'h00);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped error", {31'h0, errv}, 32'h1);
    for (int i = NUM_REG-1; i >= 0; i--) apb(1'b1, REG_OFF[i], wpat[i]);
    for (int i = 0; i < NUM_REG; i++) rdchk(REG_OFF[i], rexp[i]);
    chk("group rise", {28'h0, grpSeen}, 32'hf);
    for (int i = NUM_REG-1; i >= 0; i--) apb(1'b1, REG_OFF[i], 8'h00);
    w0 = wakeCnt;
    pulse(17'h1ffff);
    for (int i = 0; i < NUM_REG; i++) rdchk(REG_OFF[i], eexp[i]);
    chk("wake", {31'h0, wakeCnt > w0}, 32'h1);
    for (int i = NUM_REG-1; i >= 0; i--) apb(1'b1, REG_OFF[i], 8'h00);
    apb(1'b1, OFF_PRIMARY, 8'h03);
    apb(1'b1, OFF_CTRL, 8'h11);
    @(posedge clock);
    extPin2 <= 1'b1;
    wait_load(1);
    chk("vector", {20'h0, loadLog[0]}, {20'h0, VEC_PIN2});
    chk("pushed", {20'h0, pushLog[0]}, 32'h100);
    rdchk(OFF_PRIMARY, 8'h03);
    rdchk(OFF_CTRL, 8'h10);
    ret();
    wait_load(2);
    chk("return", {20'h0, loadLog[1]}, 32'h100);
    apb(1'b1, OFF_PRIMARY, 8'h33);
    repeat (8) @(posedge clock);
    chk("blocked", loadCnt, 2);
    apb(1'b1, OFF_CTRL, 8'h11);
    wait_load(3);
    chk("first", {20'h0, loadLog[2]}, {20'h0, VEC_PIN2});
    rdchk(OFF_PRIMARY, 8'h23);
    apb(1'b1, OFF_CTRL, 8'h11);
    wait_load(4);
    chk("second", {20'h0, loadLog[3]}, {20'h0, VEC_PIN3});
    chk("pushed", {20'h0, pushLog[2]}, {20'h0, VEC_PIN2});
    apb(1'b1, OFF_PRIMARY, 8'h13);
    apb(1'b1, OFF_CTRL, 8'h11);
    repeat (8) @(posedge clock);
    chk("full", loadCnt, 4);
    ret();
    wait_load(6);
    chk("pop", {20'h0, loadLog[4]}, {20'h0, VEC_PIN2});
    chk("after pop", {20'h0, loadLog[5]}, {20'h0, VEC_PIN2});
    // Free one stack entry so that only the enable can block
    ret();
    wait_load(7);
    chk("pop again", {20'h0, loadLog[6]}, {20'h0, pushLog[3]});
    apb(1'b1, OFF_PRIMARY, 8'h20);
    apb(1'b1, OFF_CTRL, 8'h11);
    repeat (8) @(posedge clock);
    chk("disabled", loadCnt, 7);
    rdchk(OFF_PRIMARY, 8'h20);
    apb(1'b1, OFF_PRIMARY, 8'h04);
    apb(1'b1, OFF_TMR3, 8'h02);
    pulse(17'h00008);
    wait_load(8);
    chk("group", {20'h0, loadLog[7]}, {20'h0, VEC_GRP4});
    rdchk(OFF_TMR3, 8'h22);
    rdchk(OFF_PRIMARY, 8'h04);
    // Pin 3 on falling edges only
    apb(1'b1, OFF_PRIMARY, 8'h00);
    apb(1'b1, OFF_CTRL, 8'h80);
    @(posedge clock);
    extPin3 <= 1'b1;
    repeat (3) @(posedge clock);
    rdchk(OFF_PRIMARY, 8'h00);
    extPin3 <= 1'b0;
    repeat (3) @(posedge clock);
    rdchk(OFF_PRIMARY, 8'h20);
    end_of_test();
  end
endmodule : tb_top

/* verilog/mfic_ctrl.sv */
// Module: multi-function interrupt controller with APB registers
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps

// Function
// - Primary register: group 5/4 flags bits 7/6, pin 3/2 flags 5/4, enables 3..0.
// - Timer 0 group register: four compare flags bits 7..4, enables 3..0.
// - Timer 1 group register uses the same layout as timer 0.
// - UART group: UART1/UART0 flags bits 5/4, enables 1/0, rest read zero.
// - A source event sets its flag whatever the enable.
// - A set flag jumps only when its enable is one.
// - Global enable low blocks every vector jump.
// - On acceptance push next address, load vector into program counter.
// - Return instruction pops saved address into the program counter.
// - Servicing clears the global enable automatically.
// - Requests during service latch and are serviced once enabled again.
// - Stack full: no request is acknowledged.
// - Simultaneous requests resolved by fixed priority.
// - Pins have own vectors, groups 4 and 5 each share one vector.
// - Any flag becoming set wakes the device.
// - Edge select: 00 off, 01 rising, 10 falling, 11 both.
// - Group flag sets when its enabled member requests go from none set to any set.
// - Group service clears only the group flag, not members.
// - Pin service clears that pin's flag and the global enable.
module mfic_ctrl
  import mfic_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extPin2,
  input wire logic extPin3,
  input wire logic [3:0] tmr0Event,
  input wire logic [3:0] tmr1Event,
  input wire logic [1:0] tmr2Event,
  input wire logic serialEvent,
  input wire logic eepromEvent,
  input wire logic lowVoltEvent,
  input wire logic [1:0] tmr3Event,
  input wire logic [1:0] uartEvent,
  input wire logic [PC_W-1:0] nextPc,
  input wire logic stackFull,
  input wire logic retInstr,
  input wire logic [PC_W-1:0] popAddr,
  output logic stackPush,
  output logic [PC_W-1:0] stackPushAddr,
  output logic pcLoad,
  output logic [PC_W-1:0] pcLoadAddr,
  output logic [3:0] groupSet,
  output logic wake
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [NUM_REG-1:0][7:0] regs;
    logic [7:0] ctrl;
    logic [1:0] prevPin;
    logic [NUM_GRP-1:0] prevReq;
    logic [DEPTH_W-1:0] depth;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic stackPush;
    logic [PC_W-1:0] stackPushAddr;
    logic pcLoad;
    logic [PC_W-1:0] pcLoadAddr;
    logic [3:0] groupSet;
    logic wake;
  } mfic_state_t;

  mfic_state_t st;
  mfic_state_t next_st;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    logic [NUM_REG-1:0][7:0] hwSet;
    logic [NUM_GRP-1:0] memReq;
    logic [1:0] pinNow;
    logic [1:0] sel;
    logic [3:0] pend;
    logic access;
    logic hit;
    logic [31:0] rdata;
    logic [7:0] flagsOld;
    logic [7:0] flagsNew;
    logic anyRise;
    hwSet = '0;
    memReq = '0;
    pinNow = {extPin3, extPin2};
    sel = 2'h0;
    pend = 4'h0;
    access = psel & penable;
    hit = 1'b0;
    rdata = 32'h0;
    flagsOld = 8'h0;
    flagsNew = 8'h0;
    anyRise = 1'b0;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.stackPush = 1'b0;
    next_st.pcLoad = 1'b0;
    next_st.groupSet = 4'h0;
    next_st.wake = 1'b0;
    next_st.prevPin = pinNow;

    // Pin edge detection
    for (int p = 0; p < 2; p++)
    begin
      sel = (p == 0) ? st.ctrl[SEL_PIN2_LO +: 2] : st.ctrl[SEL_PIN3_LO +: 2];
      hwSet[0][BIT_PIN2_F + p] =
        (sel[0] & pinNow[p] & ~st.prevPin[p]) |
        (sel[1] & ~pinNow[p] & st.prevPin[p]);
    end

    // Member source events
    hwSet[1][7:4] = tmr0Event;
    hwSet[2][7:4] = tmr1Event;
    hwSet[3][5:4] = tmr2Event;
    hwSet[4][7] = serialEvent;
    hwSet[4][5] = eepromEvent;
    hwSet[4][4] = lowVoltEvent;
    hwSet[5][5:4] = tmr3Event;
    hwSet[6][5:4] = uartEvent;

    // Group request edges
    for (int g = 0; g < NUM_GRP; g++)
    begin
      memReq[g] = |(st.regs[g + 1][7:4] & st.regs[g + 1][3:0] & REQ_MASK[g]);
    end
    next_st.prevReq = memReq;
    next_st.groupSet = memReq[3:0] & ~st.prevReq[3:0];
    hwSet[0][BIT_GRP4_F] = memReq[4] & ~st.prevReq[4];
    hwSet[0][BIT_GRP5_F] = memReq[5] & ~st.prevReq[5];

    // Register bus decode
    for (int i = 0; i < NUM_REG; i++)
    begin
      if (paddr == REG_OFF[i])
      begin
        hit = 1'b1;
        rdata = {24'h0, st.regs[i] & WR_MASK[i]};
      end
    end
    if (paddr == OFF_CTRL)
    begin
      hit = 1'b1;
      rdata = {24'h0, st.ctrl};
    end
    if (paddr == OFF_STATUS)
    begin
      hit = 1'b1;
      rdata = {27'h0, stackFull, st.depth};
    end

    // First access cycle: capture read data, answer next
    if (access && !st.pready)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = ~hit;
      next_st.prdata = hit ? rdata : 32'h0;
    end

    // Write takes effect on the completing edge
    if (access && st.pready && pwrite && !st.pslverr)
    begin
      for (int i = 0; i < NUM_REG; i++)
      begin
        if (paddr == REG_OFF[i])
        begin
          next_st.regs[i] = pwdata[7:0] & WR_MASK[i];
        end
      end
      if (paddr == OFF_CTRL)
      begin
        next_st.ctrl = pwdata[7:0];
      end
    end

    // Pending requests gated by enables
    pend[0] = st.regs[0][BIT_PIN2_F] & st.regs[0][BIT_PIN2_E];
    pend[1] = st.regs[0][BIT_PIN3_F] & st.regs[0][BIT_PIN3_E];
    pend[2] = st.regs[0][BIT_GRP4_F] & st.regs[0][BIT_GRP4_E];
    pend[3] = st.regs[0][BIT_GRP5_F] & st.regs[0][BIT_GRP5_E];

    // Return from a service routine
    if (retInstr)
    begin
      next_st.pcLoad = 1'b1;
      next_st.pcLoadAddr = popAddr;
      if (st.depth != '0)
      begin
        next_st.depth = st.depth - 1'b1;
      end
    end
    else if (st.ctrl[BIT_GIE] && !stackFull && (pend != 4'h0))
    begin
      next_st.stackPush = 1'b1;
      next_st.stackPushAddr = nextPc;
      next_st.pcLoad = 1'b1;
      next_st.ctrl[BIT_GIE] = 1'b0;
      if (st.depth != DEPTH_MAX)
      begin
        next_st.depth = st.depth + 1'b1;
      end
      if (pend[0])
      begin
        next_st.pcLoadAddr = VEC_PIN2;
        next_st.regs[0][BIT_PIN2_F] = 1'b0;
      end
      else if (pend[1])
      begin
        next_st.pcLoadAddr = VEC_PIN3;
        next_st.regs[0][BIT_PIN3_F] = 1'b0;
      end
      else if (pend[2])
      begin
        next_st.pcLoadAddr = VEC_GRP4;
        next_st.regs[0][BIT_GRP4_F] = 1'b0;
      end
      else
      begin
        next_st.pcLoadAddr = VEC_GRP5;
        next_st.regs[0][BIT_GRP5_F] = 1'b0;
      end
    end

    // Hardware sets win over any clear
    for (int i = 0; i < NUM_REG; i++)
    begin
      next_st.regs[i] = next_st.regs[i] | hwSet[i];
      flagsOld = st.regs[i] & WR_MASK[i] & 8'hf0;
      flagsNew = next_st.regs[i] & WR_MASK[i] & 8'hf0;
      anyRise = anyRise | (|(flagsNew & ~flagsOld));
    end
    next_st.wake = anyRise;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.regs <= {NUM_REG{RST_REG}};
      st.ctrl <= RST_CTRL;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign stackPush = st.stackPush;
  assign stackPushAddr = st.stackPushAddr;
  assign pcLoad = st.pcLoad;
  assign pcLoadAddr = st.pcLoadAddr;
  assign groupSet = st.groupSet;
  assign wake = st.wake;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  gie_blocks_a: assert property (
    stackPush |-> $past(st.ctrl[BIT_GIE]))
    else $error("vector taken with global enable low");

  stack_full_a: assert property (
    stackPush |-> !$past(stackFull))
    else $error("vector taken with stack full");

  gie_cleared_a: assert property (
    stackPush |-> !st.ctrl[BIT_GIE])
    else $error("global enable not cleared on service");

  push_addr_a: assert property (
    stackPush |-> pcLoad && stackPushAddr == $past(nextPc))
    else $error("wrong pushed address");

  ret_pop_a: assert property (
    retInstr |=> pcLoad && !stackPush && pcLoadAddr == $past(popAddr))
    else $error("return did not load popped address");

  enable_gate_a: assert property (
    stackPush && pcLoadAddr == VEC_GRP4
      |-> $past(st.regs[0][BIT_GRP4_E] && st.regs[0][BIT_GRP4_F]))
    else $error("group 4 vector without enabled flag");

  prio_order_a: assert property (
    stackPush && pcLoadAddr == VEC_PIN3
      |-> !$past(st.regs[0][BIT_PIN2_F] && st.regs[0][BIT_PIN2_E]))
    else $error("pin 3 served over pending pin 2");

  flag_set_a: assert property (
    tmr0Event[3] |=> st.regs[1][7])
    else $error("timer 0 event did not set flag");

  wake_rise_a: assert property (
    uartEvent[0] && !st.regs[6][4] |=> wake)
    else $error("new flag did not wake");

endmodule : mfic_ctrl

/* verilog/mfic_pkg.sv */
// Package: constants of the multi-function interrupt control block
package mfic_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int PC_W = 12;
  localparam int NUM_REG = 7;
  localparam int NUM_GRP = 6;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFF_PRIMARY = 8'h00;
  localparam logic [7:0] OFF_TMR0 = 8'h04;
  localparam logic [7:0] OFF_TMR1 = 8'h08;
  localparam logic [7:0] OFF_TMR2 = 8'h0c;
  localparam logic [7:0] OFF_SER = 8'h10;
  localparam logic [7:0] OFF_TMR3 = 8'h14;
  localparam logic [7:0] OFF_UART = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [NUM_REG-1:0][7:0] REG_OFF = {
    OFF_UART, OFF_TMR3, OFF_SER, OFF_TMR2,
    OFF_TMR1, OFF_TMR0, OFF_PRIMARY};

  // ==========================================================
  // Reset values and masks
  // ==========================================================
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // Writable bits per register, index 0 is the primary one
  localparam logic [NUM_REG-1:0][7:0] WR_MASK = {
    8'h33, 8'hff, 8'hff, 8'h33, 8'hff, 8'hff, 8'hff};
  // Implemented flag/enable pairs of each group register
  localparam logic [NUM_GRP-1:0][3:0] REQ_MASK = {
    4'h3, 4'h3, 4'hb, 4'h3, 4'hf, 4'hf};

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int FLAG_LO = 4;
  localparam int BIT_PIN2_F = 4;
  localparam int BIT_PIN3_F = 5;
  localparam int BIT_GRP4_F = 6;
  localparam int BIT_GRP5_F = 7;
  localparam int BIT_PIN2_E = 0;
  localparam int BIT_PIN3_E = 1;
  localparam int BIT_GRP4_E = 2;
  localparam int BIT_GRP5_E = 3;
  localparam int BIT_GIE = 0;
  localparam int SEL_PIN2_LO = 4;
  localparam int SEL_PIN3_LO = 6;
  localparam int DEPTH_W = 4;
  localparam logic [DEPTH_W-1:0] DEPTH_MAX = 4'hf;

  // ==========================================================
  // Edge select codes
  // ==========================================================
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ==========================================================
  // Vector addresses, ascending order is priority order
  // ==========================================================
  localparam logic [PC_W-1:0] VEC_PIN2 = 12'h00c;
  localparam logic [PC_W-1:0] VEC_PIN3 = 12'h010;
  localparam logic [PC_W-1:0] VEC_GRP4 = 12'h014;
  localparam logic [PC_W-1:0] VEC_GRP5 = 12'h018;

endpackage : mfic_pkg
